// File: bench/pin_source.sv
// Model of the outside world at the port: eight pin levels and the core's sleep level.
// Assumes the bench calls its tasks; every change lands just after a rising edge.
`timescale 1ns/1ps
module pin_source
  import pin_change_pkg::*;
(
  input  wire logic            clk,   // System clock.
  output logic [PIN_COUNT-1:0] pins,  // Port pin levels.
  output logic                 sleep  // High while the core sleeps.
);
  // Pins are push-pull sources, so a level is always present and never floats.
  initial begin
    pins  = '0;
    sleep = 1'b0;
  end

  // Move the pins to a new level just after an edge, as a synchronous source would.
  task automatic drive(input logic [PIN_COUNT-1:0] v);
    @(posedge clk);
    pins <= v;
  endtask : drive

  // Enter or leave sleep; the block synchronises this level itself.
  task automatic set_sleep(input logic s);
    @(posedge clk);
    sleep <= s;
  endtask : set_sleep
endmodule : pin_source

// File: bench/tb_pin_change_irq.sv
// Self-checking bench for the pin change interrupt block.
// Assumes the pin source model and classic single Wishbone cycles from this bench.
`timescale 1ns/1ps
module tb_pin_change_irq
  import pin_change_pkg::*;
;
  logic                 sys_clk = 1'b0; // 100 MHz clock.
  logic                 rst;            // Held for three cycles at the start.
  logic                 wb_cyc;         // Bus cycle.
  logic                 wb_stb;         // Bus strobe.
  logic                 wb_we;          // Bus write enable.
  logic [ADDR_W-1:0]    wb_adr;         // Bus byte address.
  logic [3:0]           wb_sel;         // Bus byte selects.
  logic [DATA_W-1:0]    wb_dat;         // Bus write data.
  logic [DATA_W-1:0]    dat_o;          // Read data.
  logic                 ack;            // Acknowledge.
  logic [PIN_COUNT-1:0] pins;           // Pin levels from the model.
  logic                 sleep;          // Sleep level from the model.
  logic                 change_irq;     // Change interrupt.
  logic                 wake_req;       // Wake request.
  logic                 evt_irq;        // Event interrupt.
  logic [DATA_W-1:0]    seen;           // Last word read.
  int                   n_errors = 0;   // Mismatches.
  int                   n_tests  = 0;   // Comparisons.

  // Clock.
  always #5 sys_clk = ~sys_clk;

  pin_change_irq i_dut (.SYS_CLK(sys_clk), .RST(rst), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
    .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .PORT_PIN_INPUT(pins), .SLEEP_IN(sleep), .CHANGE_IRQ(change_irq),
    .WAKE_REQ(wake_req), .EVT_IRQ(evt_irq));
  pin_source i_src (.clk(sys_clk), .pins(pins), .sleep(sleep));

  // Verdict and end of run.
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // Compare with case equality so an unknown never matches.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One classic cycle; the latency is not assumed, only bounded against a hang.
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_dat <= {24'h0, wd};
    @(posedge sys_clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    seen = dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      $display("[FAIL] ack expected 1 seen timeout");
    end
  endtask : bus

  // Register write of the low byte with all four byte lanes selected.
  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    bus(1'b1, adr, d, 4'hf);
  endtask : wr

  // Register read compared as a whole word; upper bits must read zero.
  task automatic rd(input string what, input logic [7:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 8'h00, 4'hf);
    chk(what, {24'h0, exp}, seen);
  endtask : rd

  // Pin changes need two sync stages, a compare and the flag; six edges leave margin.
  task automatic settle();
    repeat (6) @(posedge sys_clk);
  endtask : settle

  // Callers take output checks at the falling edge, where the registered values have settled.
  task automatic look(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask : look

  // Main sequence.
  initial begin
    rst    = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we  = 1'b0;
    wb_adr = '0;
    wb_sel = '0;
    wb_dat = '0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd("rise_en reset", OFS_RISE_EN, RESET_BYTE);
    rd("fall_en reset", OFS_FALL_EN, RESET_BYTE);
    rd("flags reset", OFS_FLAGS, RESET_BYTE);
    rd("control reset", OFS_CONTROL, RESET_BYTE);
    rd("unmapped", 8'h20, 8'h00);
    // With every enable off, edges on all pins leave the flags clear.
    i_src.drive(8'hff);
    i_src.drive(8'h00);
    settle();
    rd("flags disabled", OFS_FLAGS, 8'h00);
    rd("evt idle", OFS_EVT_STATUS, 8'h00);
    // Split polarities per pin; a write without lane zero must be ignored.
    wr(OFS_RISE_EN, 8'h0f);
    wr(OFS_FALL_EN, 8'hf0);
    bus(1'b1, OFS_RISE_EN, 8'hff, 4'he);
    rd("rise_en kept", OFS_RISE_EN, 8'h0f);
    i_src.drive(8'hff);
    settle();
    rd("flags rise", OFS_FLAGS, 8'h0f);
    @(negedge sys_clk);
    look("irq master off", 1'b0, change_irq);
    look("wake master off", 1'b0, wake_req);
    look("evt masked", 1'b0, evt_irq);
    rd("summary set", OFS_CONTROL, 8'h02);
    wr(OFS_EVT_MASK, 8'h01);
    @(negedge sys_clk);
    look("evt unmasked", 1'b1, evt_irq);
    rd("evt status", OFS_EVT_STATUS, 8'h01);
    @(negedge sys_clk);
    look("evt cleared", 1'b0, evt_irq);
    i_src.drive(8'h00);
    settle();
    rd("flags fall", OFS_FLAGS, 8'hff);
    // Clear only the bits known to be set, by an AND mask.
    rd("flags before", OFS_FLAGS, 8'hff);
    wr(OFS_FLAGS, seen[7:0] ^ 8'hff);
    rd("flags cleared", OFS_FLAGS, 8'h00);
    wr(OFS_FLAGS, 8'hff);
    rd("flags write one", OFS_FLAGS, 8'h00);
    rd("summary clear", OFS_CONTROL, 8'h00);
    // Both polarities on pin 0, and a falling edge racing a clear of pins 0 and 1.
    wr(OFS_RISE_EN, 8'h03);
    wr(OFS_FALL_EN, 8'h01);
    i_src.drive(8'h03);
    settle();
    rd("flags both rise", OFS_FLAGS, 8'h03);
    i_src.drive(8'h02);
    repeat (1) @(posedge sys_clk);
    wr(OFS_FLAGS, 8'h00);
    rd("edge wins clear", OFS_FLAGS, 8'h01);
    wr(OFS_FLAGS, 8'h00);
    // Master on while asleep: interrupt and wake, flags already visible.
    wr(OFS_CONTROL, 8'h01);
    i_src.set_sleep(1'b1);
    i_src.drive(8'h03);
    settle();
    @(negedge sys_clk);
    look("irq master on", 1'b1, change_irq);
    look("wake", 1'b1, wake_req);
    rd("flags at wake", OFS_FLAGS, 8'h01);
    rd("control awake", OFS_CONTROL, 8'h07);
    rd("evt wake", OFS_EVT_STATUS, 8'h03);
    i_src.set_sleep(1'b0);
    wr(OFS_FLAGS, 8'h00);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    look("irq after clear", 1'b0, change_irq);
    look("wake after clear", 1'b0, wake_req);
    // A reset in mid-run with pins held high: enables clear and no false edge follows.
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    wr(OFS_RISE_EN, 8'h03);
    settle();
    rd("flags after reset", OFS_FLAGS, 8'h00);
    rd("fall_en after reset", OFS_FALL_EN, RESET_BYTE);
    rd("control after reset", OFS_CONTROL, RESET_BYTE);
    end_sim();
  end

  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    $display("[FAIL] run expected done seen hang");
    end_sim();
  end
endmodule : tb_pin_change_irq

// File: design/pin_change_irq.sv
// Pin change interrupt controller for one eight-pin input port, Wishbone slave.
// Assumes a classic Wishbone master on SYS_CLK and asynchronous pins.
// What this block does
// - all eight pins usable, any combination
// - separate rising and falling detector per pin
// - rising enable bit arms rising detection
// - falling enable bit arms falling detection
// - both bits set detects either edge
// - zero disables; enables reset to zero
// - enabled edge sets sticky pin flag
// - change interrupt raised only with master enable; EVT_IRQ edge event is not gated by it
// - flags keep setting when master disabled
// - summary flag is OR of pin flags
// - writing zero clears a pin flag
// - edge during flag write keeps flag set
// - enabled edge wakes device when master set
// - flags updated before wake is signalled
`timescale 1ns/1ps
module pin_change_irq
  import pin_change_pkg::*;
#(
  parameter int PINS = PIN_COUNT                // Pins of the port.
) (
  input  wire logic              SYS_CLK,       // System clock, 100 MHz.
  input  wire logic              RST,           // Synchronous reset, active high.
  input  wire logic              WB_CYC_I,      // Wishbone cycle.
  input  wire logic              WB_STB_I,      // Wishbone strobe.
  input  wire logic              WB_WE_I,       // Wishbone write enable.
  input  wire logic [ADDR_W-1:0] WB_ADR_I,      // Wishbone byte address.
  input  wire logic [3:0]        WB_SEL_I,      // Wishbone byte selects.
  input  wire logic [DATA_W-1:0] WB_DAT_I,      // Wishbone write data.
  output logic      [DATA_W-1:0] WB_DAT_O,      // Wishbone read data.
  output logic                   WB_ACK_O,      // Wishbone acknowledge.
  input  wire logic [PINS-1:0]   PORT_PIN_INPUT, // Port pin levels.
  input  wire logic              SLEEP_IN,      // High while the core sleeps.
  output logic                   CHANGE_IRQ,    // Pin change interrupt request.
  output logic                   WAKE_REQ,      // Wake request to the core.
  output logic                   EVT_IRQ        // Event interrupt line.
);

  // All state of the block except the pin synchroniser in one packed struct.
  typedef struct packed {
    logic [PINS-1:0] rise_enable;               // Rising edge enable bits.
    logic [PINS-1:0] fall_enable;               // Falling edge enable bits.
    logic [PINS-1:0] flags;                     // Sticky per-pin change flags.
    logic            master_en;                 // Master change interrupt enable.
    logic [1:0]      evt_status;                // Sticky events: [0] edge, [1] wake.
    logic [1:0]      evt_mask;                  // Event mask, same layout.
    logic            ack;                       // Bus acknowledge.
    logic [DATA_W-1:0] rdata;                   // Registered read data.
    logic            wake;                      // Registered wake request.
    logic            irq;                       // Registered change interrupt.
    logic [1:0]      sleep_sync;                // Sleep input synchroniser.
  } state_s;

  state_s st;                                   // Registered state.
  state_s next_st;                              // Next state.
  wb_req_s req;                                 // Bus request bundled.
  logic [PINS-1:0] rise;                        // Rising edge pulses.
  logic [PINS-1:0] fall;                        // Falling edge pulses.
  logic [PINS-1:0] hit;                         // Armed edges seen this cycle.
  logic            access;                      // New bus access this cycle.
  logic [7:0]      wbyte;                       // Low write byte after lane select.

  // Bundle the bus inputs.
  assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I, sel: WB_SEL_I, dat: WB_DAT_I};

  // Pin synchroniser and edge detector for all pins at once.
  pin_edge_sync #(
    .WIDTH (PINS)
  ) u_sync (
    .clk  (SYS_CLK),
    .rst  (RST),
    .pins (PORT_PIN_INPUT),
    .rise (rise),
    .fall (fall)
  );

  // Each pin takes its own armed edges; one generate loop covers them.
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      // Either polarity counts when both enables are set; zero disables it.
      assign hit[g] = (rise[g] & st.rise_enable[g]) | (fall[g] & st.fall_enable[g]);
    end
  endgenerate

  // Acknowledge one cycle after the strobe, then drop so each access ends.
  assign access = req.cyc & req.stb & ~st.ack;
  // Only lane zero carries the eight-bit registers.
  assign wbyte  = req.sel[0] ? req.dat[7:0] : RESET_BYTE;

  // Next state: bus writes, flag setting, events and outputs.
  always_comb begin
    next_st            = st;
    next_st.ack        = access;
    next_st.sleep_sync = {st.sleep_sync[0], SLEEP_IN};
    next_st.rdata      = '0;
    // A register write changes only the selected byte lane.
    if (access && req.we && req.sel[0]) begin
      unique case (req.adr)
        OFS_RISE_EN:    next_st.rise_enable = wbyte[PINS-1:0];
        OFS_FALL_EN:    next_st.fall_enable = wbyte[PINS-1:0];
        OFS_FLAGS:      next_st.flags       = st.flags & wbyte[PINS-1:0];
        OFS_CONTROL:    next_st.master_en   = wbyte[CTRL_MASTER_EN];
        OFS_EVT_MASK:   next_st.evt_mask    = wbyte[1:0];
        default:        next_st.master_en   = st.master_en;           // Unmapped writes are dropped.
      endcase
    end
    // Reads return the register in the low byte; unmapped reads give zero.
    if (access && !req.we) begin
      unique case (req.adr)
        OFS_RISE_EN:    next_st.rdata[PINS-1:0] = st.rise_enable;
        OFS_FALL_EN:    next_st.rdata[PINS-1:0] = st.fall_enable;
        OFS_FLAGS:      next_st.rdata[PINS-1:0] = st.flags;
        OFS_CONTROL:    next_st.rdata[2:0] = {st.sleep_sync[1], |st.flags, st.master_en};
        OFS_EVT_STATUS: next_st.rdata[1:0] = st.evt_status;
        OFS_EVT_MASK:   next_st.rdata[1:0] = st.evt_mask;
        default:        next_st.rdata = '0;
      endcase
      // Reading the status register clears it.
      if (req.adr == OFS_EVT_STATUS) begin
        next_st.evt_status = 2'h0;
      end
    end
    // Hardware sets win over any clear, whether write or read.
    next_st.flags = next_st.flags | hit;
    if (|hit) begin
      next_st.evt_status[0] = 1'b1;
    end
    // The wake and interrupt follow the flag register, so flags are ready first.
    next_st.irq  = st.master_en & (|st.flags);
    next_st.wake = st.master_en & st.sleep_sync[1] & (|st.flags);
    if (next_st.wake) begin
      next_st.evt_status[1] = 1'b1;
    end
  end

  // Register the whole state; reset clears every enable and flag.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs from flops, except the event line, combined from event status and mask.
  assign WB_ACK_O   = st.ack;
  assign WB_DAT_O   = st.rdata;
  assign CHANGE_IRQ = st.irq;
  assign WAKE_REQ   = st.wake;
  assign EVT_IRQ    = |(st.evt_status & st.evt_mask);

  // Summary flag as seen by software, for the checks below.
  logic summary;
  assign summary = |st.flags;

  // An armed edge is a flag one cycle later.
  property p_edge_sets_flag;
    @(posedge SYS_CLK) disable iff (RST) (|hit) |=> ((st.flags & $past(hit)) == $past(hit));
  endproperty
  a_edge_sets_flag: assert property (p_edge_sets_flag) else $error("armed edge did not set flag");

  // A disarmed rising edge never sets a flag by itself.
  property p_disarmed_ignored;
    @(posedge SYS_CLK) disable iff (RST) (rise[0] && !st.rise_enable[0] && !st.flags[0] && !access) |=> !st.flags[0];
  endproperty
  a_disarmed_ignored: assert property (p_disarmed_ignored) else $error("disarmed edge set flag");

  // Edge during a flag clearing write still leaves the flag set.
  property p_set_wins;
    @(posedge SYS_CLK) disable iff (RST) (access && req.we && req.adr == OFS_FLAGS && hit[0]) |=> st.flags[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new edge");

  // A zero write with no edge clears the flag.
  property p_zero_clears;
    @(posedge SYS_CLK) disable iff (RST)
      (access && req.we && req.sel[0] && req.adr == OFS_FLAGS && !req.dat[0] && !hit[0]) |=> !st.flags[0];
  endproperty
  a_zero_clears: assert property (p_zero_clears) else $error("zero write left flag set");

  // Interrupt follows flags only with the master enable.
  property p_irq_gated;
    @(posedge SYS_CLK) disable iff (RST) CHANGE_IRQ |-> $past(st.master_en) && $past(summary);
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("interrupt without master enable");

  // Flags keep setting with the master enable off.
  property p_flags_without_master;
    @(posedge SYS_CLK) disable iff (RST) (!st.master_en && |hit) |=> summary ##1 (CHANGE_IRQ == $past(st.master_en));
  endproperty
  a_flags_without_master: assert property (p_flags_without_master) else $error("flags stopped");

  // Wake is raised within two cycles of an edge in sleep, flag already set.
  sequence s_sleep_edge;
    st.master_en && st.sleep_sync[1] && (|hit);
  endsequence
  property p_wake;
    @(posedge SYS_CLK) disable iff (RST)
      s_sleep_edge ##1 (st.master_en && st.sleep_sync[1] && !access) |=> ##[0:1] (WAKE_REQ && summary);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake after edge");

  // A rising edge pulse lasts one cycle only.
  property p_pulse;
    @(posedge SYS_CLK) disable iff (RST) rise[0] |=> !rise[0];
  endproperty
  a_pulse: assert property (p_pulse) else $error("edge pulse too long");

  // Acknowledge comes one cycle after a fresh request and lasts one cycle.
  property p_ack;
    @(posedge SYS_CLK) disable iff (RST) access |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("bad acknowledge timing");

  // The checks below watch internal state on SYS_CLK; all but the reset check stay quiet while reset is held.
  // Five of them look at pin 0 only; the generate loop makes every pin the same logic,
  // so one pin stands for all of them without eight copies of each property.

  // Reset leaves every enable, flag and the master enable clear.
  property p_reset_clears;
    @(posedge SYS_CLK)
      RST |=> (st.rise_enable == '0) && (st.fall_enable == '0) && (st.flags == '0) && !st.master_en;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left state set");

  // A rising edge on an armed pin becomes its flag one cycle later.
  property p_rise_armed;
    @(posedge SYS_CLK) disable iff (RST) (rise[0] && st.rise_enable[0]) |=> st.flags[0];
  endproperty
  a_rise_armed: assert property (p_rise_armed) else $error("armed rising edge lost");

  // A falling edge on an armed pin becomes its flag one cycle later.
  property p_fall_armed;
    @(posedge SYS_CLK) disable iff (RST) (fall[0] && st.fall_enable[0]) |=> st.flags[0];
  endproperty
  a_fall_armed: assert property (p_fall_armed) else $error("armed falling edge lost");

  // With both enables set, either polarity raises the flag.
  property p_both_armed;
    @(posedge SYS_CLK) disable iff (RST)
      ((rise[0] || fall[0]) && st.rise_enable[0] && st.fall_enable[0]) |=> st.flags[0];
  endproperty
  a_both_armed: assert property (p_both_armed) else $error("edge of either polarity lost");

  // A set flag stays set until a bus access could clear it.
  property p_flag_sticky;
    @(posedge SYS_CLK) disable iff (RST) (st.flags[0] && !access) |=> st.flags[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself");

  // With the master enable on, any set flag raises the interrupt one cycle later.
  property p_irq_follows;
    @(posedge SYS_CLK) disable iff (RST) (st.master_en && summary) |=> CHANGE_IRQ;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt missing");

  // With the master enable off, neither request leaves the block.
  property p_master_off_quiet;
    @(posedge SYS_CLK) disable iff (RST) !st.master_en |=> (!CHANGE_IRQ && !WAKE_REQ);
  endproperty
  a_master_off_quiet: assert property (p_master_off_quiet) else $error("request with master enable off");

  // The summary cannot rise without an armed edge behind it.
  property p_no_spurious;
    @(posedge SYS_CLK) disable iff (RST) (!summary && !(|hit)) |=> !summary;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("summary rose without an edge");

  // A flag write can only clear: a clear flag with no edge stays clear whatever is written.
  property p_write_never_sets;
    @(posedge SYS_CLK) disable iff (RST)
      (access && req.we && (req.adr == OFS_FLAGS) && !st.flags[0] && !hit[0]) |=> !st.flags[0];
  endproperty
  a_write_never_sets: assert property (p_write_never_sets) else $error("flag write set a flag");

  // Wake is only raised from a flag already in place, asleep, with the master enable on.
  property p_wake_needs;
    @(posedge SYS_CLK) disable iff (RST)
      WAKE_REQ |-> ($past(summary) && $past(st.master_en) && $past(st.sleep_sync[1]));
  endproperty
  a_wake_needs: assert property (p_wake_needs) else $error("wake without a flag");

  // Reading the event status clears the edge event unless a new edge lands in that cycle.
  property p_evt_read_clears;
    @(posedge SYS_CLK) disable iff (RST)
      (access && !req.we && (req.adr == OFS_EVT_STATUS) && !(|hit)) |=> !st.evt_status[0];
  endproperty
  a_evt_read_clears: assert property (p_evt_read_clears) else $error("event status survived its read");

  // A flag read answers in the next cycle with the flags as they stood when it was taken.
  sequence s_flag_read;
    access && !req.we && (req.adr == OFS_FLAGS);
  endsequence
  property p_flag_read;
    @(posedge SYS_CLK) disable iff (RST) s_flag_read |=> (WB_ACK_O && (WB_DAT_O[PINS-1:0] == $past(st.flags)));
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag read returned stale data");

  // Read data stays zero outside the acknowledge, so a stray sample shows nothing stale.
  property p_idle_data_zero;
    @(posedge SYS_CLK) disable iff (RST) !WB_ACK_O |-> (WB_DAT_O == '0);
  endproperty
  a_idle_data_zero: assert property (p_idle_data_zero) else $error("read data outside acknowledge");

endmodule : pin_change_irq

// File: design/pin_edge_sync.sv
// Synchroniser and edge detector for the port pins.
// Assumes pins are asynchronous to SYS_CLK; one instance covers all pins.
`timescale 1ns/1ps
module pin_edge_sync
  import pin_change_pkg::*;
#(
  parameter int WIDTH = PIN_COUNT               // Number of pins watched.
) (
  input  wire logic             clk,            // System clock.
  input  wire logic             rst,            // Synchronous reset, active high.
  input  wire logic [WIDTH-1:0] pins,           // Raw pin levels.
  output logic      [WIDTH-1:0] rise,           // One-cycle rising edge pulses.
  output logic      [WIDTH-1:0] fall            // One-cycle falling edge pulses.
);

  // The state of this module kept as one packed struct.
  typedef struct packed {
    logic [WIDTH-1:0] meta;                     // First stage, read only by the second.
    logic [WIDTH-1:0] sync;                     // Second stage, safe to use.
    logic [WIDTH-1:0] prev;                     // Previous synchronised sample.
    logic [2:0]       primed;                   // Fills with ones as real samples reach each stage.
  } sync_s;

  sync_s st;                                    // Registered state.
  sync_s next_st;                               // Next state.

  // Shift the pins through two flops and keep one older sample.
  always_comb begin
    next_st      = st;
    next_st.meta = pins;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
    next_st.primed = {st.primed[1:0], 1'b1};
  end

  // Register the state; reset puts every stage low.
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Compare the safe sample with the older one, one pulse per transition.
  // Edges stay masked until the older sample holds a real pin level, so a pin that is
  // high through reset gives no false rising edge; a change in those cycles is not seen.
  assign rise = st.sync & ~st.prev & {WIDTH{st.primed[2]}};
  assign fall = ~st.sync & st.prev & {WIDTH{st.primed[2]}};

endmodule : pin_edge_sync

// File: include/pin_change_pkg.sv
// Constants and carrier types for the pin change interrupt block.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
package pin_change_pkg;

  localparam int          PIN_COUNT      = 8;             // Pins of the watched port.
  localparam int          ADDR_W         = 8;             // Byte address width of the slave.
  localparam int          DATA_W         = 32;            // Wishbone data width.
  localparam logic [7:0]  OFS_RISE_EN    = 8'h00;         // Rising edge enable register.
  localparam logic [7:0]  OFS_FALL_EN    = 8'h04;         // Falling edge enable register.
  localparam logic [7:0]  OFS_FLAGS      = 8'h08;         // Per-pin change flags.
  localparam logic [7:0]  OFS_CONTROL    = 8'h0c;         // Master enable and summary flag.
  localparam logic [7:0]  OFS_EVT_STATUS = 8'h10;         // Sticky event status, clear on read.
  localparam logic [7:0]  OFS_EVT_MASK   = 8'h14;         // Event mask.
  localparam int          CTRL_MASTER_EN = 0;             // Bit of the master enable.
  localparam int          CTRL_SUMMARY   = 1;             // Bit of the summary flag (read only).
  localparam int          CTRL_SLEEP     = 2;             // Bit of the sleep state (read only).
  localparam logic [7:0]  RESET_BYTE     = 8'h00;         // Reset value of every register.

  // Wishbone request from the master.
  typedef struct packed {
    logic                cyc;
    logic                stb;
    logic                we;
    logic [ADDR_W-1:0]   adr;
    logic [3:0]          sel;
    logic [DATA_W-1:0]   dat;
  } wb_req_s;

  // Wishbone answer to the master.
  typedef struct packed {
    logic                ack;
    logic [DATA_W-1:0]   dat;
  } wb_rsp_s;

endpackage : pin_change_pkg
